// File: logic/vsi_line1_status.sv
// line-1 interrupt status block: raw and enabled status, enables, axi4-lite slave
// assumes event pulses and bus inputs synchronous to clk_i; ce_i low freezes all state
//
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/1ps
module vsi_line1_status (
  // clock, reset, enable
  input  wire logic             clk_i,
  input  wire logic             rst_b_i,
  input  wire logic             ce_i,
  // source event pulses
  input  wire vsi_pkg::vsi_evt_t evt_i,
  // axi4-lite write address
  input  wire logic             awvalid_i,
  input  wire logic [7:0]       awaddr_i,
  output logic                  awready_o,
  // axi4-lite write data
  input  wire logic             wvalid_i,
  input  wire logic [31:0]      wdata_i,
  input  wire logic [3:0]       wstrb_i,
  output logic                  wready_o,
  // axi4-lite write response
  output logic                  bvalid_o,
  output logic [1:0]            bresp_o,
  input  wire logic             bready_i,
  // axi4-lite read address
  input  wire logic             arvalid_i,
  input  wire logic [7:0]       araddr_i,
  output logic                  arready_o,
  // axi4-lite read data
  output logic                  rvalid_o,
  output logic [31:0]           rdata_o,
  output logic [1:0]            rresp_o,
  input  wire logic             rready_i,
  // interrupt line
  output logic                  irq_o
);

  // status and enable storage
  logic [31:0] raw_a_r;
  logic [31:0] raw_a_nxt;
  logic [31:0] raw_b_r;
  logic [31:0] raw_b_nxt;
  logic [31:0] en_a_r;
  logic [31:0] en_b_r;

  // bus holding registers
  logic        aw_got_r;
  logic [7:0]  aw_addr_r;
  logic        w_got_r;
  logic [31:0] w_data_r;
  logic [3:0]  w_strb_r;
  logic        awready_r;
  logic        wready_r;
  logic        bvalid_r;
  logic [1:0]  bresp_r;
  logic        arready_r;
  logic        rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;
  logic        irq_r;

  // handshake decode
  wire logic aw_fire = awvalid_i && awready_r;
  wire logic w_fire  = wvalid_i && wready_r;
  wire logic ar_fire = arvalid_i && arready_r;
  wire logic b_fire  = bvalid_r && bready_i;
  wire logic r_fire  = rvalid_r && rready_i;

  // a write is performed once address and data are both held and no response waits
  wire logic wr_do = aw_got_r && w_got_r && !bvalid_r;

  // byte lanes that the strobes let through
  wire logic [31:0] wr_lanes = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}},
                                {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
  wire logic [31:0] wr_ones  = w_data_r & wr_lanes;

  // write address decode
  wire logic wr_raw_a = wr_do && (aw_addr_r == vsi_pkg::ADDR_RAW_A);
  wire logic wr_raw_b = wr_do && (aw_addr_r == vsi_pkg::ADDR_RAW_B);
  wire logic wr_ena_a = wr_do && (aw_addr_r == vsi_pkg::ADDR_ENA_A);
  wire logic wr_ena_b = wr_do && (aw_addr_r == vsi_pkg::ADDR_ENA_B);
  wire logic wr_en_a  = wr_do && (aw_addr_r == vsi_pkg::ADDR_EN_A);
  wire logic wr_en_b  = wr_do && (aw_addr_r == vsi_pkg::ADDR_EN_B);
  wire logic wr_hit   = wr_raw_a || wr_raw_b || wr_ena_a || wr_ena_b || wr_en_a || wr_en_b;

  // set and clear terms; a zero bit in the write data produces neither
  wire logic [31:0] set_a = wr_raw_a ? wr_ones : 32'h0000_0000;
  wire logic [31:0] set_b = wr_raw_b ? wr_ones : 32'h0000_0000;
  wire logic [31:0] clr_a = wr_ena_a ? wr_ones : 32'h0000_0000;
  wire logic [31:0] clr_b = wr_ena_b ? wr_ones : 32'h0000_0000;

  // enabled view of the pending bits
  wire logic [31:0] ena_a = raw_a_r & en_a_r;
  wire logic [31:0] ena_b = raw_b_r & en_b_r;

  // pending update: an event or software set in the clearing cycle wins over the clear
  assign raw_a_nxt = ((raw_a_r & ~clr_a) | evt_i.line_a | set_a) & vsi_pkg::MASK_A;
  assign raw_b_nxt = ((raw_b_r & ~clr_b) | evt_i.line_b | set_b) & vsi_pkg::MASK_B;

  // read decode; unmapped offsets return zero and an error response
  wire logic [31:0] rd_word =
    (araddr_i == vsi_pkg::ADDR_RAW_A) ? raw_a_r :
    (araddr_i == vsi_pkg::ADDR_RAW_B) ? raw_b_r :
    (araddr_i == vsi_pkg::ADDR_ENA_A) ? ena_a   :
    (araddr_i == vsi_pkg::ADDR_ENA_B) ? ena_b   :
    (araddr_i == vsi_pkg::ADDR_EN_A)  ? en_a_r  :
    (araddr_i == vsi_pkg::ADDR_EN_B)  ? en_b_r  : vsi_pkg::RST_WORD;
  wire logic rd_hit = (araddr_i == vsi_pkg::ADDR_RAW_A) || (araddr_i == vsi_pkg::ADDR_RAW_B) ||
                      (araddr_i == vsi_pkg::ADDR_ENA_A) || (araddr_i == vsi_pkg::ADDR_ENA_B) ||
                      (araddr_i == vsi_pkg::ADDR_EN_A)  || (araddr_i == vsi_pkg::ADDR_EN_B);

  // the interrupt flop takes pending bits after this cycle's update and the enables before it, so it changes with the raw bits
  wire logic irq_nxt = |(raw_a_nxt & en_a_r) || |(raw_b_nxt & en_b_r);

  // pending status
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      raw_a_r <= vsi_pkg::RST_WORD;
      raw_b_r <= vsi_pkg::RST_WORD;
    end else if (ce_i) begin
      raw_a_r <= raw_a_nxt;
      raw_b_r <= raw_b_nxt;
    end
  end

  // per-source enables, plain read/write; reserved bits never stick
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      en_a_r <= vsi_pkg::RST_WORD;
      en_b_r <= vsi_pkg::RST_WORD;
    end else if (ce_i) begin
      if (wr_en_a) en_a_r <= ((en_a_r & ~wr_lanes) | wr_ones) & vsi_pkg::MASK_A;
      if (wr_en_b) en_b_r <= ((en_b_r & ~wr_lanes) | wr_ones) & vsi_pkg::MASK_B;
    end
  end

  // interrupt output flop
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      irq_r <= 1'b0;
    end else if (ce_i) begin
      irq_r <= irq_nxt;
    end
  end

  // write address channel: one held address, ready drops until the response is taken
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      aw_got_r  <= 1'b0;
      aw_addr_r <= 8'h00;
      awready_r <= 1'b1;
    end else if (ce_i) begin
      if (aw_fire) begin
        aw_got_r  <= 1'b1;
        aw_addr_r <= awaddr_i;
        awready_r <= 1'b0;
      end else if (b_fire) begin
        aw_got_r  <= 1'b0;
        awready_r <= 1'b1;
      end
    end
  end

  // write data channel, independent of the address so either may come first
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      w_got_r  <= 1'b0;
      w_data_r <= vsi_pkg::RST_WORD;
      w_strb_r <= 4'h0;
      wready_r <= 1'b1;
    end else if (ce_i) begin
      if (w_fire) begin
        w_got_r  <= 1'b1;
        w_data_r <= wdata_i;
        w_strb_r <= wstrb_i;
        wready_r <= 1'b0;
      end else if (b_fire) begin
        w_got_r  <= 1'b0;
        wready_r <= 1'b1;
      end
    end
  end

  // write response, one cycle after the write is performed
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      bvalid_r <= 1'b0;
      bresp_r  <= vsi_pkg::RESP_OKAY;
    end else if (ce_i) begin
      if (wr_do) begin
        bvalid_r <= 1'b1;
        bresp_r  <= wr_hit ? vsi_pkg::RESP_OKAY : vsi_pkg::RESP_SLVERR;
      end else if (b_fire) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // read channel: data captured at the address handshake, held until taken
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rdata_r   <= vsi_pkg::RST_WORD;
      rresp_r   <= vsi_pkg::RESP_OKAY;
    end else if (ce_i) begin
      if (ar_fire) begin
        arready_r <= 1'b0;
        rvalid_r  <= 1'b1;
        rdata_r   <= rd_word;
        rresp_r   <= rd_hit ? vsi_pkg::RESP_OKAY : vsi_pkg::RESP_SLVERR;
      end else if (r_fire) begin
        arready_r <= 1'b1;
        rvalid_r  <= 1'b0;
      end
    end
  end

  // outputs straight from flops
  assign awready_o = awready_r;
  assign wready_o  = wready_r;
  assign bvalid_o  = bvalid_r;
  assign bresp_o   = bresp_r;
  assign arready_o = arready_r;
  assign rvalid_o  = rvalid_r;
  assign rdata_o   = rdata_r;
  assign rresp_o   = rresp_r;
  assign irq_o     = irq_r;

  // checks on the block's own behaviour
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  // an event pulse leaves its bit pending on the next edge
  property p_evt_sets_raw;
    ce_i |=> ((raw_a_r & $past(evt_i.line_a & vsi_pkg::MASK_A))
              == $past(evt_i.line_a & vsi_pkg::MASK_A));
  endproperty
  a_evt_sets_raw: assert property (p_evt_sets_raw)
    else $error("event pulse did not set raw a bit");

  // software write of ones into raw b sets those bits
  property p_sw_set;
    (ce_i && wr_raw_b) |=> ((raw_b_r & $past(wr_ones & vsi_pkg::MASK_B))
                            == $past(wr_ones & vsi_pkg::MASK_B));
  endproperty
  a_sw_set: assert property (p_sw_set)
    else $error("software set of raw bit failed");

  // a pending bit only falls through an explicit clear
  property p_hold_pending;
    ce_i |=> (($past(raw_a_r) & ~$past(clr_a) & ~raw_a_r) == 32'h0000_0000);
  endproperty
  a_hold_pending: assert property (p_hold_pending)
    else $error("raw bit dropped without clear");

  // read of enabled status returns raw and enable at the handshake
  property p_ena_read;
    (ce_i && ar_fire && araddr_i == vsi_pkg::ADDR_ENA_A)
      |=> rvalid_o && (rdata_o == $past(raw_a_r & en_a_r));
  endproperty
  a_ena_read: assert property (p_ena_read)
    else $error("enabled status read value wrong");

  // clearing through enabled status drops the pending bit unless re-set
  property p_w1c;
    ce_i |=> ((raw_b_r & $past(clr_b & ~evt_i.line_b & ~set_b)) == 32'h0000_0000);
  endproperty
  a_w1c: assert property (p_w1c)
    else $error("write one to clear did not clear");

  // reserved raw bits never read as one
  property p_reserved;
    ((raw_a_r & ~vsi_pkg::MASK_A) == 32'h0000_0000)
      && ((raw_b_r & ~vsi_pkg::MASK_B) == 32'h0000_0000);
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved raw bit set");

  // interrupt line follows the updated pending bits and the prior cycle's enables
  property p_irq;
    ce_i |=> (irq_o == (|$past(raw_a_nxt & en_a_r) || |$past(raw_b_nxt & en_b_r)));
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt output mismatch");

  // interrupt low when nothing enabled is pending, one cycle on
  property p_irq_quiet;
    (ce_i && (ena_a == 32'h0000_0000) && (ena_b == 32'h0000_0000)
      && (evt_i.line_a == 32'h0000_0000) && (evt_i.line_b == 32'h0000_0000) && !wr_do)
      |=> !irq_o;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet)
    else $error("interrupt high with nothing enabled");

  // write response appears exactly one cycle after the write
  property p_bresp;
    (ce_i && wr_do) |=> bvalid_o;
  endproperty
  a_bresp: assert property (p_bresp)
    else $error("write response missing");

  // clearing through enabled status b is the only way a raw b bit falls
  property p_raw_b_hold;
    ce_i |=> (($past(raw_b_r) & ~$past(clr_b) & ~raw_b_r) == 32'h0000_0000);
  endproperty
  a_raw_b_hold: assert property (p_raw_b_hold)
    else $error("raw b bit dropped without clear");

  // the film mode detect event lands in its own raw a bit
  property p_film_mode;
    (ce_i && evt_i.line_a[vsi_pkg::POS_FILM_MODE]) |=> raw_a_r[vsi_pkg::POS_FILM_MODE];
  endproperty
  a_film_mode: assert property (p_film_mode)
    else $error("film mode event not captured");

  // the dma client event lands in its own raw b bit
  property p_dma_client;
    (ce_i && evt_i.line_b[vsi_pkg::POS_DMA_CLIENT]) |=> raw_b_r[vsi_pkg::POS_DMA_CLIENT];
  endproperty
  a_dma_client: assert property (p_dma_client)
    else $error("dma client event not captured");

  // the sd encoder bit of enabled status a reads as raw and enable
  property p_sd_enc_read;
    (ce_i && ar_fire && araddr_i == vsi_pkg::ADDR_ENA_A) |=> (rdata_o[vsi_pkg::POS_SD_ENCODER]
      == $past(raw_a_r[vsi_pkg::POS_SD_ENCODER] && en_a_r[vsi_pkg::POS_SD_ENCODER]));
  endproperty
  a_sd_enc_read: assert property (p_sd_enc_read)
    else $error("sd encoder enabled status read wrong");

  // a taken write address is held and no second one is accepted
  property p_aw_hold;
    (ce_i && aw_fire) |=> (!awready_o && aw_got_r);
  endproperty
  a_aw_hold: assert property (p_aw_hold)
    else $error("write address ready did not drop");

  // a taken read address answers next cycle and blocks the next request
  property p_ar_hold;
    (ce_i && ar_fire) |=> (!arready_o && rvalid_o);
  endproperty
  a_ar_hold: assert property (p_ar_hold)
    else $error("read answer missing after address handshake");

  // main scenarios
  c_w1c:     cover property (ce_i && wr_ena_a && |(clr_a & raw_a_r));
  c_set_win: cover property (ce_i && |(clr_a & evt_i.line_a));
  c_irq:     cover property (!irq_o ##1 irq_o);
  c_rd_err:  cover property (ce_i && ar_fire && !rd_hit);

endmodule

// File: logic/vsi_pkg.sv
// package for the line-1 interrupt status block: offsets, field layout, types
// assumes a 32-bit axi4-lite register bus with byte addresses in the low 8 bits
// Summary of operation
// - raw status bit reads 1 while its event is pending, regardless of enable
// - software writing 1 to a raw bit sets it like a source event
// - software writing 0 to a raw bit leaves it unchanged
// - enabled-status bit reads 1 when its source is pending and enabled
// - writing 1 to an enabled-status bit clears that source's pending state
// - writing 0 to an enabled-status bit leaves pending state untouched
// - raw b bits 25..22 hold capture port chroma downsampler uv errors
// - raw b bit 21 noise filter, 20 compositor, 19..17 graphics, 16 deinterlacer
// - raw b bit 7 dma client event, bits 6..0 dma channel groups
// - raw a bit 18 film mode detect; bits 19 and 17 reserved zero
// - raw a bit 16 holds the dma descriptor event
// - raw a bits 15..0 are list pairs 7..0, odd notify, even complete
// - enabled a bit 31 sd encoder, 30..28 and 24..22 output port events
// - enabled a bits 21,20 capture parsers; bits 27..25 reserved zero
package vsi_pkg;

  // register byte offsets
  localparam logic [7:0] ADDR_RAW_A = 8'h40;
  localparam logic [7:0] ADDR_RAW_B = 8'h44;
  localparam logic [7:0] ADDR_ENA_A = 8'h48;
  localparam logic [7:0] ADDR_ENA_B = 8'h4C;
  localparam logic [7:0] ADDR_EN_A  = 8'h50;
  localparam logic [7:0] ADDR_EN_B  = 8'h54;

  // field positions, register a
  localparam int POS_SD_ENCODER     = 31;
  localparam int POS_VOUT2_EVT0     = 28;
  localparam int POS_VOUT1_EVT0     = 22;
  localparam int POS_CAP_PARSER1    = 20;
  localparam int POS_FILM_MODE      = 18;
  localparam int POS_DMA_DESCRIPTOR = 16;
  localparam int POS_DMA_LIST0      = 0;
  // field positions, register b
  localparam int POS_CAP1_UV1       = 22;
  localparam int POS_NOISE_UV       = 21;
  localparam int POS_COMPOSITOR     = 20;
  localparam int POS_GFX1           = 17;
  localparam int POS_DEINT_ERROR    = 16;
  localparam int POS_DMA_CLIENT     = 7;
  localparam int POS_DMA_GROUP0     = 0;

  // implemented bits; everything else reads zero
  localparam logic [31:0] MASK_A = 32'hF1F5_FFFF;
  localparam logic [31:0] MASK_B = 32'h03FF_00FF;

  // reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  // axi response codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // one pulse per source, in register bit order
  typedef struct packed {
    logic [31:0] line_b;
    logic [31:0] line_a;
  } vsi_evt_t;

endpackage

// File: verif/vsi_evt_src.sv
// event source model: the video modules that raise events into the status block
// assumes bench requests change just after a rising clk_i edge
`timescale 1ns/1ps
module vsi_evt_src (
  // clock, reset
  input  wire logic              clk_i,
  input  wire logic              rst_b_i,
  // request from the bench
  input  wire logic              go_i,
  input  wire vsi_pkg::vsi_evt_t sel_i,
  input  wire logic [3:0]        len_i,
  // event lines into the block
  output vsi_pkg::vsi_evt_t      evt_o
);
  logic [3:0] left_r;

  // a source holds its event for len_i cycles, the same length for every selected source
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      left_r <= 4'h0;
      evt_o  <= 64'h0;
    end else if (go_i) begin
      left_r <= len_i;
      evt_o  <= sel_i;
    end else if (left_r > 4'h1) begin
      left_r <= left_r - 4'h1;
    end else begin
      left_r <= 4'h0;
      evt_o  <= 64'h0;
    end
  end
endmodule

// File: verif/testbench.sv
// self-checking bench for the line-1 interrupt status block
// assumes one 100 ns clock; the bench acts as axi4-lite master, the model as sources
`timescale 1ns/1ps
module testbench;
  logic              clk_i, rst_b_i, ce_i, go, awvalid, wvalid, bready, arvalid, rready;
  logic              awready, wready, bvalid, arready, rvalid, irq;
  logic [7:0]        awaddr, araddr;
  logic [31:0]       wdata, rdata;
  logic [3:0]        wstrb, len;
  logic [1:0]        bresp, rresp;
  vsi_pkg::vsi_evt_t sel, evt;
  int                miscompares, n_compared;

  vsi_evt_src src_u (.clk_i(clk_i), .rst_b_i(rst_b_i), .go_i(go), .sel_i(sel), .len_i(len),
    .evt_o(evt));
  vsi_line1_status dut_u (.clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i), .evt_i(evt),
    .awvalid_i(awvalid), .awaddr_i(awaddr), .awready_o(awready), .wvalid_i(wvalid),
    .wdata_i(wdata), .wstrb_i(wstrb), .wready_o(wready), .bvalid_o(bvalid), .bresp_o(bresp),
    .bready_i(bready), .arvalid_i(arvalid), .araddr_i(araddr), .arready_o(arready),
    .rvalid_o(rvalid), .rdata_o(rdata), .rresp_o(rresp), .rready_i(rready), .irq_o(irq));

  // free-running clock
  always #50 clk_i = ~clk_i;

  task close_out;
    if (miscompares == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // write: address and data offered together, each released once taken
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
          output logic [1:0] resp);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk_i);
      if (!aw_ok && awready) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b1;
    do @(posedge clk_i); while (!bvalid);
    resp = bresp;
    bready <= 1'b0;
  endtask

  task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    arvalid <= 1'b1;
    araddr <= a;
    do @(posedge clk_i); while (!arready);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge clk_i); while (!rvalid);
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  task wrok(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [1:0] r;
    wr(a, d, s, r);
    chk("bresp", {30'h0, vsi_pkg::RESP_OKAY}, {30'h0, r});
  endtask

  task rdchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk("rdata", exp, d);
    chk("rresp", {30'h0, vsi_pkg::RESP_OKAY}, {30'h0, r});
  endtask

  // the level seen here was settled by the previous edge
  task irqchk(input logic exp);
    @(posedge clk_i);
    chk("irq", {31'h0, exp}, {31'h0, irq});
  endtask

  task fire(input vsi_pkg::vsi_evt_t s, input logic [3:0] l);
    go <= 1'b1;
    sel <= s;
    len <= l;
    @(posedge clk_i);
    go <= 1'b0;
    repeat (l + 1) @(posedge clk_i);
  endtask

  // every register reads zero out of reset
  task t_reset;
    logic [7:0] a;
    for (int i = 0; i < 6; i++) begin
      a = vsi_pkg::ADDR_RAW_A + 8'(4 * i);
      rdchk(a, vsi_pkg::RST_WORD);
    end
    irqchk(1'b0);
  endtask

  // pending with enables off, then enabled view, W0 and W1 on enabled status
  task t_masked;
    fire(64'hFFFF_FFFF_FFFF_FFFF, 4'h3);
    rdchk(vsi_pkg::ADDR_RAW_A, vsi_pkg::MASK_A);
    rdchk(vsi_pkg::ADDR_RAW_B, vsi_pkg::MASK_B);
    rdchk(vsi_pkg::ADDR_ENA_A, 32'h0000_0000);
    irqchk(1'b0);
    wrok(vsi_pkg::ADDR_EN_A, 32'hFFFF_FFFF, 4'hF);
    wrok(vsi_pkg::ADDR_EN_B, 32'hFFFF_FFFF, 4'hF);
    rdchk(vsi_pkg::ADDR_ENA_A, vsi_pkg::MASK_A);
    rdchk(vsi_pkg::ADDR_ENA_B, vsi_pkg::MASK_B);
    irqchk(1'b1);
    wrok(vsi_pkg::ADDR_ENA_A, 32'h0000_0000, 4'hF);
    rdchk(vsi_pkg::ADDR_RAW_A, vsi_pkg::MASK_A);
    wrok(vsi_pkg::ADDR_ENA_A, 32'hFFFF_FFFF, 4'hF);
    wrok(vsi_pkg::ADDR_ENA_B, 32'hFFFF_FFFF, 4'hF);
    rdchk(vsi_pkg::ADDR_RAW_A, 32'h0000_0000);
    rdchk(vsi_pkg::ADDR_RAW_B, 32'h0000_0000);
    irqchk(1'b0);
  endtask

  // one source at a time, varying pulse length, so a swapped field shows
  task t_walk;
    logic [63:0] bit_v;
    logic [31:0] word, exp;
    logic        lo;
    for (int i = 0; i < 64; i++) begin
      bit_v = 64'h1 << i;
      lo = (i < 32);
      word = lo ? bit_v[31:0] : bit_v[63:32];
      exp = word & (lo ? vsi_pkg::MASK_A : vsi_pkg::MASK_B);
      fire(bit_v, 4'(i % 3) + 4'h1);
      rdchk(lo ? vsi_pkg::ADDR_RAW_A : vsi_pkg::ADDR_RAW_B, exp);
      irqchk(|exp);
      wrok(lo ? vsi_pkg::ADDR_ENA_A : vsi_pkg::ADDR_ENA_B, word, 4'hF);
    end
  endtask

  // software set, write of zero, byte lanes, then unmapped access
  task t_sw_set;
    logic [31:0] d;
    logic [1:0]  r;
    wrok(vsi_pkg::ADDR_RAW_A, 32'h0000_0001, 4'hF);
    wrok(vsi_pkg::ADDR_RAW_A, 32'h0000_0000, 4'hF);
    rdchk(vsi_pkg::ADDR_RAW_A, 32'h0000_0001);
    wrok(vsi_pkg::ADDR_RAW_A, 32'hFFFF_FFFF, 4'h2);
    rdchk(vsi_pkg::ADDR_RAW_A, 32'h0000_FF01);
    irqchk(1'b1);
    wrok(vsi_pkg::ADDR_RAW_B, 32'hFFFF_FFFF, 4'hF);
    rdchk(vsi_pkg::ADDR_RAW_B, vsi_pkg::MASK_B);
    wrok(vsi_pkg::ADDR_ENA_A, 32'hFFFF_FFFF, 4'hF);
    wrok(vsi_pkg::ADDR_ENA_B, 32'hFFFF_FFFF, 4'hF);
    wr(8'h58, 32'hFFFF_FFFF, 4'hF, r);
    chk("bresp", {30'h0, vsi_pkg::RESP_SLVERR}, {30'h0, r});
    rd(8'h58, d, r);
    chk("rdata", 32'h0000_0000, d);
    chk("rresp", {30'h0, vsi_pkg::RESP_SLVERR}, {30'h0, r});
    rdchk(vsi_pkg::ADDR_RAW_B, 32'h0000_0000);
    irqchk(1'b0);
  endtask

  // events seen while the clock enable is low must not be captured
  task t_freeze;
    ce_i <= 1'b0;
    fire(64'h0000_0000_0000_0001, 4'h1);
    ce_i <= 1'b1;
    rdchk(vsi_pkg::ADDR_RAW_A, 32'h0000_0000);
    irqchk(1'b0);
  endtask

  // hang guard, well beyond the several hundred cycles the run needs
  initial begin
    #1_000_000;
    miscompares++;
    close_out;
  end

  initial begin
    clk_i = 1'b0;
    rst_b_i = 1'b0;
    ce_i = 1'b1;
    go = 1'b0;
    sel = 64'h0;
    len = 4'h1;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0000_0000;
    wstrb = 4'h0;
    miscompares = 0;
    n_compared = 0;
    repeat (2) @(posedge clk_i);
    rst_b_i <= 1'b1;
    @(posedge clk_i);
    t_reset;
    t_masked;
    t_walk;
    t_sw_set;
    t_freeze;
    close_out;
  end
endmodule
